// ===== logic/pbc_pkg.sv
// Constants shared by the packet buffer control block and its receive FIFO.
// Assumes one 20 MHz clock and a host that reaches registers through plain ports.
//
// What this block does
// - Two bank-select bits choose register bank 0 to 3 for the host port.
// - Transmit-reset bit set holds the transmit logic in reset.
// - Receive-reset bit set holds the receive logic in reset.
// - Writing DMA start launches an operation; bit reads one while DMA busy.
// - DMA mode bit picks checksum (one) or buffer copy (zero).
// - Transmit request reads one while a packet is being sent, zero when idle.
// - Receive enable one stores passing packets; zero ignores all incoming packets.
// - Writing packet-decrement one lowers the pending count by one, then self-clears.
// - Power-save bit signals MAC and PHY sleep and stalls receive and transmit; DMA keeps running.
// - Regulator low-current bit acts only while power save is on.
// - Control-two bits 2..0 read zero; host keeps reserved bit 4 at zero.
// - Packet memory of 8 Kbytes split into host-programmed receive and transmit areas.
// - Receive region includes both its start byte and its end byte.
// - Receive bytes stored in sequence, wrapping from region end to region start.
// - Receive region may cross from the top address back to zero.
// - Receive write position is read-only, updated on each good packet.
// - Receive writes stop before the read boundary; overflow data is discarded.
// - Transmit area is everything else; pointers are not checked against receive.
// - Sequential reads wrap at receive end; sequential writes pass receive end and wrap only at the top address.

package pbc_pkg;

	localparam int ADDR_W    = 13;
	localparam int BUF_BYTES = 8192;
	localparam int SEL_W     = 5;
	localparam int FIFO_W    = 10;
	localparam int FIFO_D    = 16;

	// ==========================================================================
	// Register selects on the host port
	localparam logic [4:0] REG_CTRL_ONE  = 5'h00;
	localparam logic [4:0] REG_CTRL_TWO  = 5'h01;
	localparam logic [4:0] REG_PTR_FIRST = 5'h02;
	localparam logic [4:0] REG_PTR_LAST  = 5'h17;
	localparam logic [4:0] REG_CSUM_LO   = 5'h18;
	localparam logic [4:0] REG_CSUM_HI   = 5'h19;
	localparam logic [4:0] REG_PKT_CNT   = 5'h1a;
	localparam logic [4:0] REG_DATA      = 5'h1b;

	// ==========================================================================
	// Pointer slots, two byte selects each starting at REG_PTR_FIRST
	localparam int          PTR_N        = 11;
	localparam logic [3:0]  PTR_RX_START = 4'h0;
	localparam logic [3:0]  PTR_RX_END   = 4'h1;
	localparam logic [3:0]  PTR_RX_BOUND = 4'h2;
	localparam logic [3:0]  PTR_RX_WRPOS = 4'h3;
	localparam logic [3:0]  PTR_TX_START = 4'h4;
	localparam logic [3:0]  PTR_TX_END   = 4'h5;
	localparam logic [3:0]  PTR_HOST_RD  = 4'h6;
	localparam logic [3:0]  PTR_HOST_WR  = 4'h7;
	localparam logic [3:0]  PTR_DMA_SRC  = 4'h8;
	localparam logic [3:0]  PTR_DMA_END  = 4'h9;
	localparam logic [3:0]  PTR_DMA_DST  = 4'ha;
	localparam logic [12:0] PTR_RESET    = 13'h0000;
	localparam logic [12:0] RX_END_RESET = 13'h1fff;

	// ==========================================================================
	// Control register fields
	localparam int C1_TX_RST   = 7;
	localparam int C1_RX_RST   = 6;
	localparam int C1_DMA_GO   = 5;
	localparam int C1_DMA_CSUM = 4;
	localparam int C1_TX_REQ   = 3;
	localparam int C1_RX_EN    = 2;
	localparam int C1_BANK_LO  = 0;
	localparam int C2_AUTO_INC = 7;
	localparam int C2_PKT_DEC  = 6;
	localparam int C2_PWR_SAVE = 5;
	localparam int C2_REG_LOW  = 3;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h80;

	// ==========================================================================
	// DMA sequencer, Gray along idle -> run -> fold
	typedef enum logic [1:0] {
		PBC_DMA_IDLE = 2'b00,
		PBC_DMA_RUN  = 2'b01,
		PBC_DMA_FOLD = 2'b11
	} pbc_dma_e;

endpackage

// ===== logic/pbc_fifo.sv
// Receive byte FIFO between the link side and the packet memory writer.
// Assumes one clock; the drain side may stall, which back-pressures the link.
`timescale 1ns/1ps
`default_nettype none

module pbc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic             push;
	logic             pop;
	logic [AW:0]      next_count;

	assign push        = in_valid_i && in_ready_o && ce_i;
	assign pop         = out_valid_o && out_ready_i && ce_i;
	assign out_valid_o = (count != '0);
	assign out_data_o  = store[rd_idx];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_idx     <= '0;
			rd_idx     <= '0;
			count      <= '0;
			in_ready_o <= 1'b0;
		end else if (ce_i) begin
			if (push) begin
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			end
			if (pop) begin
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			end
			count      <= next_count;
			// Registered so the link sees a clean ready
			in_ready_o <= (next_count != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			store[wr_idx] <= in_data_i;
		end
	end

endmodule // pbc_fifo

`default_nettype wire

// ===== logic/pbc_buffer_ctrl.sv
// Packet buffer control: two control registers, pointer file, 8 Kbyte
// packet memory, receive circular FIFO, transmit reader and a small DMA.
// Assumes the host port and link streams are synchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module pbc_buffer_ctrl (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	// Host register port
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [4:0]  reg_sel_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             reg_rvalid_o,
	// Receive stream from the MAC
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_last_i,
	input  wire logic        rx_good_i,
	output logic             rx_ready_o,
	// Transmit stream to the MAC
	output logic             tx_valid_o,
	output logic      [7:0]  tx_data_o,
	output logic             tx_last_o,
	input  wire logic        tx_ready_i,
	// Side controls
	output logic      [1:0]  register_bank_select_o,
	output logic             transmit_logic_reset_o,
	output logic             receive_logic_reset_o,
	output logic             power_save_enable_o,
	output logic             regulator_low_current_o
);

	// ==========================================================================
	// Reset release
	logic rst_meta, rst_n;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================================================
	// State
	logic [7:0]           mem [pbc_pkg::BUF_BYTES];
	logic [12:0]          ptr [pbc_pkg::PTR_N];
	logic                 tx_rst, rx_rst, csum_sel, tx_req, rx_en;
	logic                 auto_inc, pwr_save, reg_low;
	logic [7:0]           pkt_cnt;
	logic [15:0]          csum, acc;
	logic                 csum_phase;
	pbc_pkg::pbc_dma_e    dma_state;
	logic [12:0]          dma_src, dma_dst, rx_wp, tx_addr;
	logic                 rx_drop;

	// ==========================================================================
	// Decodes
	logic       wr_c1, wr_c2, wr_ptr, rd_data, wr_data, ptr_hi;
	logic [3:0] ptr_id;
	logic       dma_busy, dma_wr, dma_last;
	logic       rx_take, rx_commit, rx_abort, rx_store;
	logic [9:0] f_data;
	logic       tx_load, tx_done, f_valid;
	logic [4:0] ptr_off;

	assign wr_c1   = ce_i && reg_wr_i && reg_sel_i == pbc_pkg::REG_CTRL_ONE;
	assign wr_c2   = ce_i && reg_wr_i && reg_sel_i == pbc_pkg::REG_CTRL_TWO;
	assign wr_data = ce_i && reg_wr_i && reg_sel_i == pbc_pkg::REG_DATA;
	assign rd_data = ce_i && reg_rd_i && reg_sel_i == pbc_pkg::REG_DATA;
	assign wr_ptr  = ce_i && reg_wr_i && reg_sel_i >= pbc_pkg::REG_PTR_FIRST
		&& reg_sel_i <= pbc_pkg::REG_PTR_LAST;
	assign ptr_off = reg_sel_i - pbc_pkg::REG_PTR_FIRST;
	assign ptr_id  = ptr_off[4:1];
	assign ptr_hi  = ptr_off[0];

	assign dma_busy = (dma_state != pbc_pkg::PBC_DMA_IDLE);
	assign dma_last = (dma_src == ptr[pbc_pkg::PTR_DMA_END]);
	// A host data write owns the memory port this cycle; DMA copy and receive wait
	assign dma_wr   = ce_i && dma_state == pbc_pkg::PBC_DMA_RUN && !csum_sel && !wr_data;

	// Sequential read step: wraps from receive end back to receive start
	function automatic logic [12:0] rd_step(input logic [12:0] p);
		rd_step = (p == ptr[pbc_pkg::PTR_RX_END]) ? ptr[pbc_pkg::PTR_RX_START]
			: p + 13'h0001;
	endfunction

	// ==========================================================================
	// Receive FIFO in front of the memory writer
	pbc_fifo #(
		.WIDTH (pbc_pkg::FIFO_W),
		.DEPTH (pbc_pkg::FIFO_D)
	) u_rx_fifo (
		.clk_i       (core_clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.in_valid_i  (rx_valid_i),
		.in_data_i   ({rx_good_i, rx_last_i, rx_data_i}),
		.in_ready_o  (rx_ready_o),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (rx_take)
	);

	// Receive drains stall while reset, asleep or the memory port is taken
	assign rx_take   = f_valid && ce_i && !rx_rst && !pwr_save && !wr_data && !dma_wr;
	assign rx_store  = rx_take && rx_en && !rx_drop
		&& rx_wp != ptr[pbc_pkg::PTR_RX_BOUND];
	assign rx_commit = rx_take && f_data[8] && f_data[9] && rx_store;
	assign rx_abort  = rx_take && f_data[8] && !rx_commit;

	// ==========================================================================
	// Packet memory, one write port
	always_ff @(posedge core_clk_i) begin
		if (wr_data) begin
			mem[ptr[pbc_pkg::PTR_HOST_WR]] <= reg_wdata_i;
		end else if (dma_wr) begin
			mem[dma_dst] <= mem[dma_src];
		end else if (rx_store) begin
			mem[rx_wp] <= f_data[7:0];
		end
	end

	// ==========================================================================
	// Control register one
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_rst                 <= pbc_pkg::CTRL_ONE_RESET[pbc_pkg::C1_TX_RST];
			rx_rst                 <= pbc_pkg::CTRL_ONE_RESET[pbc_pkg::C1_RX_RST];
			csum_sel               <= pbc_pkg::CTRL_ONE_RESET[pbc_pkg::C1_DMA_CSUM];
			rx_en                  <= pbc_pkg::CTRL_ONE_RESET[pbc_pkg::C1_RX_EN];
			register_bank_select_o <= pbc_pkg::CTRL_ONE_RESET[1:0];
		end else if (wr_c1) begin
			tx_rst                 <= reg_wdata_i[pbc_pkg::C1_TX_RST];
			rx_rst                 <= reg_wdata_i[pbc_pkg::C1_RX_RST];
			rx_en                  <= reg_wdata_i[pbc_pkg::C1_RX_EN];
			register_bank_select_o <= reg_wdata_i[pbc_pkg::C1_BANK_LO +: 2];
			// Mode is frozen while a DMA runs so the operation stays coherent
			if (!dma_busy) begin
				csum_sel <= reg_wdata_i[pbc_pkg::C1_DMA_CSUM];
			end
		end
	end

	assign transmit_logic_reset_o = tx_rst;
	assign receive_logic_reset_o  = rx_rst;

	// ==========================================================================
	// Control register two
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			auto_inc <= pbc_pkg::CTRL_TWO_RESET[pbc_pkg::C2_AUTO_INC];
			pwr_save <= pbc_pkg::CTRL_TWO_RESET[pbc_pkg::C2_PWR_SAVE];
			reg_low  <= pbc_pkg::CTRL_TWO_RESET[pbc_pkg::C2_REG_LOW];
			regulator_low_current_o <= pbc_pkg::CTRL_TWO_RESET[pbc_pkg::C2_REG_LOW];
		end else if (wr_c2) begin
			auto_inc <= reg_wdata_i[pbc_pkg::C2_AUTO_INC];
			pwr_save <= reg_wdata_i[pbc_pkg::C2_PWR_SAVE];
			reg_low  <= reg_wdata_i[pbc_pkg::C2_REG_LOW];
			regulator_low_current_o <= reg_wdata_i[pbc_pkg::C2_REG_LOW]
				&& reg_wdata_i[pbc_pkg::C2_PWR_SAVE];
		end
	end

	assign power_save_enable_o = pwr_save;

	// ==========================================================================
	// Pending packet counter; a new packet and a decrement cancel out
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pkt_cnt <= 8'h00;
		end else if (ce_i) begin
			if (rx_commit && !(wr_c2 && reg_wdata_i[pbc_pkg::C2_PKT_DEC])) begin
				pkt_cnt <= (pkt_cnt == 8'hff) ? pkt_cnt : pkt_cnt + 8'h01;
			end else if (!rx_commit && wr_c2 && reg_wdata_i[pbc_pkg::C2_PKT_DEC]
				&& pkt_cnt != 8'h00) begin
				pkt_cnt <= pkt_cnt - 8'h01;
			end
		end
	end

	// ==========================================================================
	// Pointer file
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < pbc_pkg::PTR_N; i++) begin
				ptr[i] <= pbc_pkg::PTR_RESET;
			end
			ptr[pbc_pkg::PTR_RX_END] <= pbc_pkg::RX_END_RESET;
		end else if (ce_i) begin
			// Receive start/end are taken as written; host keeps them still while enabled
			if (wr_ptr && ptr_id < 4'(pbc_pkg::PTR_N)
				&& ptr_id != pbc_pkg::PTR_RX_WRPOS) begin
				if (ptr_hi) begin
					ptr[ptr_id][12:8] <= reg_wdata_i[4:0];
				end else begin
					ptr[ptr_id][7:0] <= reg_wdata_i;
				end
			end
			if (rx_rst) begin
				ptr[pbc_pkg::PTR_RX_WRPOS] <= ptr[pbc_pkg::PTR_RX_START];
			end else if (rx_commit) begin
				ptr[pbc_pkg::PTR_RX_WRPOS] <= rd_step(rx_wp);
			end
			if (rd_data && auto_inc) begin
				ptr[pbc_pkg::PTR_HOST_RD] <= rd_step(ptr[pbc_pkg::PTR_HOST_RD]);
			end
			if (wr_data && auto_inc) begin
				ptr[pbc_pkg::PTR_HOST_WR] <= ptr[pbc_pkg::PTR_HOST_WR] + 13'h0001;
			end
		end
	end

	// ==========================================================================
	// Receive writer
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp   <= pbc_pkg::PTR_RESET;
			rx_drop <= 1'b0;
		end else if (ce_i) begin
			if (rx_rst) begin
				rx_wp   <= ptr[pbc_pkg::PTR_RX_START];
				rx_drop <= 1'b0;
			end else if (rx_abort) begin
				// Throw the partial packet away; stored packets stay intact
				rx_wp   <= ptr[pbc_pkg::PTR_RX_WRPOS];
				rx_drop <= 1'b0;
			end else if (rx_commit) begin
				rx_wp   <= rd_step(rx_wp);
				rx_drop <= 1'b0;
			end else if (rx_store) begin
				rx_wp   <= rd_step(rx_wp);
			end else if (rx_take) begin
				rx_drop <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Transmit reader; transmit pointers are not checked against the receive area
	assign tx_done = tx_valid_o && tx_ready_i && tx_last_o;
	assign tx_load = tx_req && !pwr_save && !(tx_valid_o && tx_last_o)
		&& (!tx_valid_o || tx_ready_i);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_req     <= pbc_pkg::CTRL_ONE_RESET[pbc_pkg::C1_TX_REQ];
			tx_addr    <= pbc_pkg::PTR_RESET;
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
			tx_last_o  <= 1'b0;
		end else if (ce_i) begin
			if (tx_rst) begin
				tx_req     <= 1'b0;
				tx_valid_o <= 1'b0;
				tx_last_o  <= 1'b0;
			end else begin
				if (wr_c1 && reg_wdata_i[pbc_pkg::C1_TX_REQ] && !tx_req) begin
					tx_req  <= 1'b1;
					tx_addr <= ptr[pbc_pkg::PTR_TX_START];
				end else if (wr_c1 && !reg_wdata_i[pbc_pkg::C1_TX_REQ]) begin
					tx_req     <= 1'b0;
					tx_valid_o <= 1'b0;
				end else if (tx_done) begin
					tx_req     <= 1'b0;
					tx_valid_o <= 1'b0;
					tx_last_o  <= 1'b0;
				end else if (tx_load) begin
					tx_valid_o <= 1'b1;
					tx_data_o  <= mem[tx_addr];
					tx_last_o  <= (tx_addr == ptr[pbc_pkg::PTR_TX_END]);
					tx_addr    <= tx_addr + 13'h0001;
				end
			end
		end
	end

	// ==========================================================================
	// DMA copy and checksum
	logic [16:0] csum_sum;
	assign csum_sum = {1'b0, acc} + (csum_phase ? {9'h000, mem[dma_src]}
		: {1'b0, mem[dma_src], 8'h00});

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dma_state  <= pbc_pkg::PBC_DMA_IDLE;
			dma_src    <= pbc_pkg::PTR_RESET;
			dma_dst    <= pbc_pkg::PTR_RESET;
			acc        <= 16'h0000;
			csum       <= 16'h0000;
			csum_phase <= 1'b0;
		end else if (ce_i) begin
			unique case (dma_state)
				pbc_pkg::PBC_DMA_IDLE: begin
					if (wr_c1 && reg_wdata_i[pbc_pkg::C1_DMA_GO]) begin
						dma_src    <= ptr[pbc_pkg::PTR_DMA_SRC];
						dma_dst    <= ptr[pbc_pkg::PTR_DMA_DST];
						acc        <= 16'h0000;
						csum_phase <= 1'b0;
						dma_state  <= pbc_pkg::PBC_DMA_RUN;
					end
				end
				pbc_pkg::PBC_DMA_RUN: begin
					if (csum_sel) begin
						acc        <= csum_sum[15:0] + {15'h0000, csum_sum[16]};
						csum_phase <= !csum_phase;
						dma_src    <= rd_step(dma_src);
						if (dma_last) begin
							dma_state <= pbc_pkg::PBC_DMA_FOLD;
						end
					end else if (dma_wr) begin
						dma_src <= rd_step(dma_src);
						dma_dst <= dma_dst + 13'h0001;
						if (dma_last) begin
							dma_state <= pbc_pkg::PBC_DMA_IDLE;
						end
					end
				end
				pbc_pkg::PBC_DMA_FOLD: begin
					csum      <= ~acc;
					dma_state <= pbc_pkg::PBC_DMA_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Register read-back, one cycle after the request
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else if (ce_i) begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				if (reg_sel_i == pbc_pkg::REG_CTRL_ONE) begin
					reg_rdata_o <= {tx_rst, rx_rst, dma_busy, csum_sel, tx_req,
						rx_en, register_bank_select_o};
				end else if (reg_sel_i == pbc_pkg::REG_CTRL_TWO) begin
					// Decrement bit always reads back cleared
					reg_rdata_o <= {auto_inc, 1'b0, pwr_save, 1'b0, reg_low,
						3'h0};
				end else if (ptr_off <= pbc_pkg::REG_PTR_LAST - pbc_pkg::REG_PTR_FIRST) begin
					reg_rdata_o <= ptr_hi ? {3'h0, ptr[ptr_id][12:8]} : ptr[ptr_id][7:0];
				end else if (reg_sel_i == pbc_pkg::REG_CSUM_LO) begin
					reg_rdata_o <= csum[7:0];
				end else if (reg_sel_i == pbc_pkg::REG_CSUM_HI) begin
					reg_rdata_o <= csum[15:8];
				end else if (reg_sel_i == pbc_pkg::REG_PKT_CNT) begin
					reg_rdata_o <= pkt_cnt;
				end else if (reg_sel_i == pbc_pkg::REG_DATA) begin
					reg_rdata_o <= mem[ptr[pbc_pkg::PTR_HOST_RD]];
				end else begin
					reg_rdata_o <= 8'h00;
				end
			end
		end
	end

endmodule // pbc_buffer_ctrl

`default_nettype wire

// ===== verification/pbc_buffer_ctrl_chk.sv
// Concurrent checks on the ports of the packet buffer control block.
// Assumes one clock domain; bound into every pbc_buffer_ctrl instance.
`timescale 1ns/1ps
`default_nettype none

module pbc_buffer_ctrl_chk (
	input wire logic       core_clk_i,
	input wire logic       arst_n_i,
	input wire logic       ce_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [4:0] reg_sel_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       reg_rvalid_o,
	input wire logic       tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       tx_ready_i,
	input wire logic [1:0] register_bank_select_o,
	input wire logic       transmit_logic_reset_o,
	input wire logic       receive_logic_reset_o,
	input wire logic       power_save_enable_o,
	input wire logic       regulator_low_current_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ==========================================================================
	// Host writes to the two control registers, read valid timing and control two zero bits
	sequence s_w1; ce_i && reg_wr_i && reg_sel_i == pbc_pkg::REG_CTRL_ONE; endsequence
	sequence s_w2; ce_i && reg_wr_i && reg_sel_i == pbc_pkg::REG_CTRL_TWO; endsequence
	property p_bank; s_w1 |=> register_bank_select_o == $past(reg_wdata_i[1:0]); endproperty
	property p_transmit_logic_reset; s_w1 |=> transmit_logic_reset_o == $past(reg_wdata_i[7]); endproperty
	property p_receive_logic_reset; s_w1 |=> receive_logic_reset_o == $past(reg_wdata_i[6]); endproperty
	property p_pwr; s_w2 |=> power_save_enable_o == $past(reg_wdata_i[5]); endproperty
	property p_vreg;
		(regulator_low_current_o |-> power_save_enable_o)
		and (s_w2 |=> regulator_low_current_o == $past(reg_wdata_i[5] && reg_wdata_i[3]));
	endproperty
	property p_rvalid; reg_rvalid_o == $past(ce_i && reg_rd_i); endproperty
	property p_c2zero;
		ce_i && reg_rd_i && reg_sel_i == pbc_pkg::REG_CTRL_TWO |=> (reg_rdata_o & 8'h57) == 8'h00;
	endproperty
	// A stalled byte may only go away through an abort write or a transmit reset
	property p_txhold;
		tx_valid_o && !tx_ready_i && !reg_wr_i && !transmit_logic_reset_o
			|=> tx_valid_o && $stable(tx_data_o);
	endproperty
	property p_txquiet; transmit_logic_reset_o [*2] |-> !tx_valid_o; endproperty
	a_bank: assert property (p_bank) else $error("bank select differs from write");
	a_transmit_logic_reset: assert property (p_transmit_logic_reset) else $error("transmit reset differs from write");
	a_receive_logic_reset: assert property (p_receive_logic_reset) else $error("receive reset differs from write");
	a_pwr: assert property (p_pwr) else $error("power save differs from write");
	a_vreg: assert property (p_vreg) else $error("low current without power save");
	a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");
	a_c2zero: assert property (p_c2zero) else $error("control two fixed bits not zero");
	a_txhold: assert property (p_txhold) else $error("transmit byte changed while stalled");
	a_txquiet: assert property (p_txquiet) else $error("transmit active in reset");
endmodule // pbc_buffer_ctrl_chk

bind pbc_buffer_ctrl pbc_buffer_ctrl_chk i_pbc_buffer_ctrl_chk (.*);

`default_nettype wire

// ===== verification/pbc_tx_sink.sv
// Transmit sink standing in for the MAC; records the first eight accepted bytes.
// Assumes the source holds valid and data until ready is seen high.
`timescale 1ns/1ps
`default_nettype none

module pbc_tx_sink (
	input  wire logic       clk_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o
);
	logic [1:0] cnt = 2'h0;
	logic [8:0] got [0:7];
	int         n   = 0;
	// One beat in four so the source must hold each byte through stalls
	assign tx_ready_o = (cnt == 2'h3);
	always @(posedge clk_i) begin
		cnt <= cnt + 2'h1;
		if (tx_valid_i && tx_ready_o && n < 8) begin
			got[n[2:0]] <= {tx_last_i, tx_data_i};
			n <= n + 1;
		end
	end
endmodule // pbc_tx_sink

`default_nettype wire

// ===== verification/tb_pbc_buffer_ctrl.sv
// Self-checking bench for the packet buffer control block.
// Assumes the design, the transmit sink and the checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end

module tb_pbc_buffer_ctrl;
	typedef struct packed {logic w; logic [4:0] s; logic [7:0] d; logic [7:0] e;} pbc_row_s;
	logic       core_clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [4:0] reg_sel_i = 5'h00;
	logic [7:0] reg_wdata_i = 8'h00, rx_data_i = 8'h00, reg_rdata_o, tx_data_o, v;
	logic       rx_valid_i = 1'b0, rx_last_i = 1'b0, rx_good_i = 1'b1, reg_rvalid_o, rx_ready_o;
	logic       tx_valid_o, tx_last_o, tx_ready_i, transmit_logic_reset_o, receive_logic_reset_o;
	logic       power_save_enable_o, regulator_low_current_o;
	logic [1:0] register_bank_select_o;
	int         num_errors = 0, compares = 0, cyc = 0;
	pbc_row_s   rows [0:15] = '{
		'{1'b0, 5'h00, 8'h00, 8'h00}, '{1'b0, 5'h01, 8'h00, 8'h80}, '{1'b0, 5'h04, 8'h00, 8'hff},
		'{1'b0, 5'h05, 8'h00, 8'h1f}, '{1'b1, 5'h00, 8'h03, 8'h03}, '{1'b1, 5'h00, 8'h02, 8'h02},
		'{1'b1, 5'h00, 8'h01, 8'h01}, '{1'b1, 5'h00, 8'hc0, 8'hc0}, '{1'b1, 5'h00, 8'h00, 8'h00},
		'{1'b1, 5'h01, 8'haf, 8'ha8}, '{1'b1, 5'h01, 8'h80, 8'h80}, '{1'b1, 5'h0b, 8'hff, 8'h1f},
		'{1'b1, 5'h0a, 8'h34, 8'h34}, '{1'b1, 5'h08, 8'h55, 8'h00}, '{1'b1, 5'h1a, 8'h05, 8'h00},
		'{1'b1, 5'h1c, 8'h5a, 8'h00}};

	always #25 core_clk_i = ~core_clk_i;

	pbc_buffer_ctrl i_pbc_buffer_ctrl (.*);
	pbc_tx_sink i_pbc_tx_sink (.clk_i(core_clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

	// ==========================================================================
	// Bus tasks
	task automatic report_and_stop();
		if (num_errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic do_reset();
		arst_n_i <= 1'b0;
		repeat (16) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
	endtask
	task automatic wr(input logic [4:0] s, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_sel_i <= s;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] s, output logic [7:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_sel_i <= s;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask
	task automatic wp(input logic [4:0] s, input logic [12:0] a);
		wr(s, a[7:0]);
		wr(s + 5'h01, {3'h0, a[12:8]});
	endtask
	// Gaps between bytes are legal and keep each strobe to one assignment per step
	task automatic pkt(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_i);
			rx_valid_i <= 1'b1;
			rx_data_i <= b + 8'(i);
			rx_last_i <= (i == n - 1);
			do @(posedge core_clk_i); while (rx_ready_o !== 1'b1);
			rx_valid_i <= 1'b0;
		end
		repeat (6) @(posedge core_clk_i);
	endtask

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		do_reset();
		for (int i = 0; i < 16; i++) begin
			if (rows[i].w) wr(rows[i].s, rows[i].d);
			rd(rows[i].s, v);
			`CHK($sformatf("row %0d", i), rows[i].e, v)
		end
		// Sequential host access around a small receive region 010..013
		wp(5'h02, 13'h0010);
		wp(5'h04, 13'h0013);
		wp(5'h10, 13'h0010);
		for (int i = 0; i < 7; i++) wr(5'h1b, 8'(i));
		wp(5'h0e, 13'h0012);
		for (int i = 0; i < 3; i++) begin
			rd(5'h1b, v);
			`CHK("wrap read", (i == 2) ? 8'h00 : 8'(2 + i), v)
		end
		wr(5'h01, 8'h00);
		wp(5'h0e, 13'h0011);
		for (int i = 0; i < 2; i++) begin
			rd(5'h1b, v);
			`CHK("no advance", 8'h01, v)
		end
		wr(5'h01, 8'h80);
		// Transmit from outside the receive region, against a stalling sink
		wp(5'h0a, 13'h0014);
		wp(5'h0c, 13'h0016);
		wr(5'h00, 8'h08);
		rd(5'h00, v);
		`CHK("tx busy", 1'b1, v[3])
		for (int k = 0; k < 60 && i_pbc_tx_sink.n < 3; k++) @(posedge core_clk_i);
		`CHK("tx count", 3, i_pbc_tx_sink.n)
		for (int k = 0; k < 3; k++) `CHK("tx byte", {k == 2, 8'(4 + k)}, i_pbc_tx_sink.got[k])
		rd(5'h00, v);
		`CHK("tx idle", 1'b0, v[3])
		// Receive: disabled, filling, overflow, boundary advance and wrap
		wp(5'h06, 13'h0013);
		wr(5'h00, 8'h40);
		wr(5'h00, 8'h00);
		pkt(8'h10, 2);
		rd(5'h1a, v);
		`CHK("rx off", 8'h00, v)
		wr(5'h00, 8'h04);
		pkt(8'h20, 3);
		pkt(8'h30, 2);
		rd(5'h1a, v);
		`CHK("rx full", 8'h01, v)
		rd(5'h08, v);
		`CHK("rx wrpos", 8'h13, v)
		wp(5'h06, 13'h0012);
		pkt(8'h40, 3);
		rd(5'h1a, v);
		`CHK("rx count", 8'h02, v)
		rd(5'h08, v);
		`CHK("rx wrpos2", 8'h12, v)
		wp(5'h0e, 13'h0010);
		for (int k = 0; k < 3; k++) begin
			rd(5'h1b, v);
			`CHK("rx data", (k == 2) ? 8'h22 : 8'(8'h41 + k), v)
		end
		wr(5'h01, 8'hc0);
		rd(5'h1a, v);
		`CHK("decrement", 8'h01, v)
		// DMA copy across the receive wrap to 020, then a checksum of the copy
		wp(5'h12, 13'h0012);
		wp(5'h14, 13'h0010);
		wp(5'h16, 13'h0020);
		wr(5'h00, 8'h20);
		rd(5'h00, v);
		`CHK("dma busy", 1'b1, v[5])
		wp(5'h0e, 13'h0020);
		for (int k = 0; k < 3; k++) begin
			rd(5'h1b, v);
			`CHK("dma copy", (k == 0) ? 8'h22 : 8'(8'h3f + k), v)
		end
		wp(5'h12, 13'h0020);
		wp(5'h14, 13'h0022);
		wr(5'h00, 8'h30);
		repeat (4) @(posedge core_clk_i);
		rd(5'h00, v);
		`CHK("dma idle", 1'b0, v[5])
		rd(5'h18, v);
		`CHK("csum lo", 8'hbf, v)
		rd(5'h19, v);
		`CHK("csum hi", 8'h9c, v)
		do_reset();
		rd(5'h01, v);
		`CHK("reset ctrl two", 8'h80, v)
		rd(5'h05, v);
		`CHK("reset rx end", 8'h1f, v)
		report_and_stop();
	end
endmodule // tb_pbc_buffer_ctrl

`default_nettype wire
